/* scrb_regs.vh */
// Operation
// - soft reset bit resets chip and registers
// - soft reset bit clears itself
// - direction bit: one increments, zero decrements
// - readback flag reads one, on serial output
// - no three-wire mode, input never driven
// - mode zero normal, three full power-down
// - maker code register read-only, fixed value
// - freeze bit holds address during streaming
`ifndef SCRB_REGS_VH
`define SCRB_REGS_VH
// ****************************************************************
// register offsets
// ****************************************************************
`define SCRB_ADDR_W          15
`define SCRB_OFS_IFACE       15'h0000
`define SCRB_OFS_PWR         15'h0002
`define SCRB_OFS_MAKER_LO    15'h000C
`define SCRB_OFS_MAKER_HI    15'h000D
`define SCRB_OFS_USR         15'h0010
// ****************************************************************
// fields and reset values
// ****************************************************************
`define SCRB_IFACE_RST       8'h30
`define SCRB_PWR_RST         8'h00
`define SCRB_USR_RST         8'h00
`define SCRB_BIT_SOFT_RESET  7
`define SCRB_BIT_ASCEND      5
`define SCRB_BIT_READBACK    4
`define SCRB_BIT_HOLD        0
`define SCRB_MODE_NORMAL     2'h0
`define SCRB_MODE_PWRDN      2'h3
// ****************************************************************
// timing
// ****************************************************************
`define SCRB_SRST_NS         750
`define SCRB_CLK_NS          25
`define SCRB_SRST_CYC        ((`SCRB_SRST_NS + `SCRB_CLK_NS - 1) / `SCRB_CLK_NS)
`endif

/* scrb_spi_config_register_bank.v */
`timescale 1ns/10ps
`default_nettype none
`include "scrb_regs.vh"
module scrb_spi_config_register_bank #(
  parameter [15:0] MAKER_CODE = 16'h5A5A  // arbitrary neutral value
) (
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire       clk_en,
  input  wire       spi_csn_pin,
  input  wire       spi_sclk_pin,
  input  wire       spi_sdi_pin,
  output reg        spi_sdo_q,
  output reg        spi_sdo_oe_n_q,
  output reg        ascend_q,
  output reg        addr_hold_q,
  output reg  [1:0] op_mode_q,
  output reg        power_down_q,
  output reg        chip_reset_q
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [1:0] csn_s_q;
  reg [1:0] sclk_s_q;
  reg [1:0] sdi_s_q;
  reg       sclk_prev_q;

  // two flops per pin; only stage 1 is read by logic
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      csn_s_q     <= 2'h3;
      sclk_s_q    <= 2'h0;
      sdi_s_q     <= 2'h0;
      sclk_prev_q <= 1'b0;
    end else if (clk_en) begin
      csn_s_q     <= {csn_s_q[0], spi_csn_pin};
      sclk_s_q    <= {sclk_s_q[0], spi_sclk_pin};
      sdi_s_q     <= {sdi_s_q[0], spi_sdi_pin};
      sclk_prev_q <= sclk_s_q[1];
    end
  end

  wire csn  = csn_s_q[1];
  wire rise = sclk_s_q[1] & ~sclk_prev_q;
  wire fall = ~sclk_s_q[1] & sclk_prev_q;
  wire sdi  = sdi_s_q[1];

  // ****************************************************************
  // registers and frame state
  // ****************************************************************
  reg  [7:0]  iface_q;
  reg  [7:0]  pwr_q;
  reg  [7:0]  usr_q;
  reg  [4:0]  bit_cnt_q;
  reg  [15:0] cmd_q;
  reg         hdr_done_q;
  reg         rd_q;
  reg  [14:0] addr_q;
  reg  [7:0]  shift_q;
  reg  [5:0]  srst_cnt_q;

  // soft reset hold time in cycles; the counter is only six bits wide
  localparam [31:0] SRST_CYC_W = `SCRB_SRST_CYC;

  // register read mux; reserved holes read zero
  function [7:0] rd_data;
    input [14:0] a;
    begin
      case (a)
        `SCRB_OFS_IFACE:    rd_data = iface_q | (8'h01 << `SCRB_BIT_READBACK);
        `SCRB_OFS_PWR:      rd_data = pwr_q;
        `SCRB_OFS_MAKER_LO: rd_data = MAKER_CODE[7:0];
        `SCRB_OFS_MAKER_HI: rd_data = MAKER_CODE[15:8];
        `SCRB_OFS_USR:      rd_data = usr_q;
        default:            rd_data = 8'h00;
      endcase
    end
  endfunction

  function [14:0] next_addr;
    input [14:0] a;
    input        hold;
    input        up;
    begin
      if (hold)
        next_addr = a;
      else if (up)
        next_addr = a + 15'h0001;
      else
        next_addr = a - 15'h0001;
    end
  endfunction

  wire [7:0] wbyte = {shift_q[6:0], sdi};

  // ****************************************************************
  // serial engine: 16-bit header (r/w, 15-bit address) then bytes
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!reset_n || srst_cnt_q != 6'h00) begin
      bit_cnt_q   <= 5'h00;
      cmd_q       <= 16'h0000;
      hdr_done_q  <= 1'b0;
      rd_q        <= 1'b0;
      addr_q      <= 15'h0000;
      shift_q     <= 8'h00;
      iface_q     <= `SCRB_IFACE_RST;
      pwr_q       <= `SCRB_PWR_RST;
      usr_q       <= `SCRB_USR_RST;
      spi_sdo_q   <= 1'b0;
      // released when no read is in progress
      spi_sdo_oe_n_q <= 1'b1;
    end else if (clk_en) begin
      if (csn) begin
        bit_cnt_q      <= 5'h00;
        hdr_done_q     <= 1'b0;
        spi_sdo_oe_n_q <= 1'b1;
      end else if (rise && !hdr_done_q) begin
        cmd_q <= {cmd_q[14:0], sdi};
        if (bit_cnt_q == 5'h0F) begin
          hdr_done_q <= 1'b1;
          rd_q       <= cmd_q[14];
          addr_q     <= {cmd_q[13:0], sdi};
          shift_q    <= rd_data({cmd_q[13:0], sdi});
          bit_cnt_q  <= 5'h00;
        end else begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
      end else if (rise) begin
        if (!rd_q)
          shift_q <= wbyte;
        if (bit_cnt_q == 5'h07) begin
          bit_cnt_q <= 5'h00;
          if (!rd_q) begin
            case (addr_q)
              `SCRB_OFS_IFACE: begin
                iface_q <= wbyte & ~(8'h01 << `SCRB_BIT_READBACK);
              end
              `SCRB_OFS_PWR: pwr_q <= wbyte;
              `SCRB_OFS_USR: usr_q <= wbyte;
              default:       iface_q <= iface_q;
            endcase
          end
          addr_q  <= next_addr(addr_q, usr_q[`SCRB_BIT_HOLD], iface_q[`SCRB_BIT_ASCEND]);
          shift_q <= rd_data(next_addr(addr_q, usr_q[`SCRB_BIT_HOLD],
                                       iface_q[`SCRB_BIT_ASCEND]));
        end else begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (rd_q)
            shift_q <= {shift_q[6:0], 1'b0};
        end
      end else if (fall && hdr_done_q && rd_q) begin
        // read data only on the serial output
        spi_sdo_q      <= shift_q[7];
        spi_sdo_oe_n_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // soft reset: held for the documented settle time, then clears
  // ****************************************************************
  // counter keeps the reset asserted long enough for the host wait window
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      srst_cnt_q   <= 6'h00;
      chip_reset_q <= 1'b0;
    end else if (clk_en) begin
      if (srst_cnt_q != 6'h00) begin
        srst_cnt_q   <= srst_cnt_q - 6'h01;
        chip_reset_q <= (srst_cnt_q != 6'h01);
      end else if (iface_q[`SCRB_BIT_SOFT_RESET]) begin
        srst_cnt_q   <= SRST_CYC_W[5:0];
        chip_reset_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // decoded configuration outputs
  // ****************************************************************
  // soft reset bit cleared by the register reload above
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      ascend_q     <= 1'b1;
      addr_hold_q  <= 1'b0;
      op_mode_q    <= `SCRB_MODE_NORMAL;
      power_down_q <= 1'b0;
    end else if (clk_en) begin
      ascend_q     <= iface_q[`SCRB_BIT_ASCEND];
      addr_hold_q  <= usr_q[`SCRB_BIT_HOLD];
      op_mode_q    <= pwr_q[1:0];
      power_down_q <= (pwr_q[1:0] == `SCRB_MODE_PWRDN);
    end
  end

endmodule // scrb_spi_config_register_bank
`default_nettype wire

/* scrb_cfg_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module scrb_cfg_checker (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       spi_csn_pin,
  input wire logic       spi_sdo_oe_n_q,
  input wire logic       ascend_q,
  input wire logic       addr_hold_q,
  input wire logic [1:0] op_mode_q,
  input wire logic       power_down_q,
  input wire logic       chip_reset_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // soft reset pulse: held, then gone
  sequence s_srst_run; chip_reset_q throughout ##27 1'b1; endsequence
  sequence s_srst_end; ##[1:4] !chip_reset_q; endsequence
  AST_SRST_LEN: assert property ($rose(chip_reset_q) |-> s_srst_run ##0 s_srst_end)
    else $error("soft reset pulse length wrong");
  AST_SRST_ONCE: assert property ($fell(chip_reset_q) |=> !chip_reset_q [*8])
    else $error("soft reset retriggered");
  AST_SRST_DEF: assert property ($fell(chip_reset_q) |-> ascend_q && !addr_hold_q && op_mode_q == 2'h0)
    else $error("registers not at defaults after soft reset");
  AST_RST_VAL: assert property ($rose(reset_n) |-> ascend_q && spi_sdo_oe_n_q && !chip_reset_q)
    else $error("outputs not at reset values");
  AST_PDN_SET: assert property ($changed(op_mode_q) |=> power_down_q == (op_mode_q == 2'h3))
    else $error("power down does not follow mode");
  AST_PDN_HOLD: assert property ($stable(op_mode_q) [*2] |-> power_down_q == (op_mode_q == 2'h3))
    else $error("power down without mode three");
  AST_OE_IDLE: assert property (spi_csn_pin [*6] |-> spi_sdo_oe_n_q)
    else $error("read line driven while deselected");
  AST_OE_SEL: assert property ($fell(spi_sdo_oe_n_q) |-> !$past(spi_csn_pin, 3))
    else $error("read line enabled outside a frame");
endmodule // scrb_cfg_checker
`default_nettype wire

/* scrb_spi_host.sv */
`timescale 1ns/10ps
`default_nettype none
module scrb_spi_host (
  input  wire logic clk_sys,
  input  wire logic sdo,
  output var  logic csn,
  output var  logic sclk,
  output var  logic sdi
);
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  initial begin
    csn = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // mode-0 frame, read from sdo only, caller gives defaults
  task automatic xfer(input logic rd, input logic [14:0] adr, input int n);
    logic [15:0] hdr;
    logic [7:0]  b;
    hdr = {rd, adr};
    rx = {};
    csn = 1'b0;
    tick(6);
    for (int i = 15; i >= 0; i--) begin
      sdi = hdr[i];
      tick(6);
      sclk = 1'b1;
      tick(6);
      sclk = 1'b0;
    end
    for (int k = 0; k < n; k++) begin
      b = rd ? 8'h00 : tx[k];
      for (int i = 7; i >= 0; i--) begin
        sdi = b[i];
        tick(6);
        sclk = 1'b1;
        b[i] = sdo;
        tick(6);
        sclk = 1'b0;
      end
      rx.push_back(b);
    end
    tick(6);
    csn = 1'b1;
    sdi = ~sdi;  // released line must not look like held data
    tick(12);
  endtask
endmodule // scrb_spi_host
`default_nettype wire

/* scrb_spi_config_register_bank_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scrb_regs.vh"
module scrb_spi_config_register_bank_test;
  localparam logic [15:0] MC = 16'hC3A5;  // arbitrary maker code
  logic clk_sys, reset_n, csn, sclk, sdi, sdo, oe_n, asc, hold, pdn, crst, srst_seen;
  logic [1:0] mode;
  int err_total, checks, cyc;
  scrb_spi_config_register_bank #(.MAKER_CODE(MC)) uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(1'b1), .spi_csn_pin(csn), .spi_sclk_pin(sclk), .spi_sdi_pin(sdi), .spi_sdo_q(sdo),
    .spi_sdo_oe_n_q(oe_n), .ascend_q(asc), .addr_hold_q(hold), .op_mode_q(mode),
    .power_down_q(pdn), .chip_reset_q(crst));
  scrb_spi_host host (.clk_sys(clk_sys), .sdo(sdo), .csn(csn), .sclk(sclk), .sdi(sdi));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.tx = {d};
    host.xfer(1'b0, a, 1);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_stream;
    wr(`SCRB_OFS_IFACE, 8'h00);
    chk("ascend", asc, 1'b0);
    host.xfer(1'b1, `SCRB_OFS_IFACE, 1);
    chk("readback", host.rx[0], 8'h10);
    host.xfer(1'b1, `SCRB_OFS_MAKER_HI, 2);
    chk("down", {host.rx[0], host.rx[1]}, MC);
    wr(`SCRB_OFS_USR, 8'h01);
    host.xfer(1'b1, `SCRB_OFS_MAKER_LO, 3);
    chk("freeze", {host.rx[1], host.rx[2]}, {2{MC[7:0]}});
    wr(`SCRB_OFS_USR, 8'h00);
    wr(`SCRB_OFS_MAKER_LO, 8'hFF);
    wr(`SCRB_OFS_IFACE, `SCRB_IFACE_RST);
    host.xfer(1'b1, `SCRB_OFS_MAKER_LO, 2);
    chk("up", {host.rx[1], host.rx[0]}, MC);
    $display("stream test done");
  endtask
  task automatic t_srst;
    wr(`SCRB_OFS_USR, 8'h01);
    wr(`SCRB_OFS_IFACE, 8'hB0);
    #(`SCRB_SRST_NS);
    chk("pulse", {srst_seen, crst}, 2'b10);
    chk("mode", {hold, mode}, 3'b000);
    host.xfer(1'b1, `SCRB_OFS_IFACE, 1);
    chk("iface", host.rx[0], `SCRB_IFACE_RST);
    $display("soft reset test done");
  endtask
  always @(posedge clk_sys) begin
    srst_seen <= srst_seen | (crst === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    reset_n = 1'b0;
    srst_seen = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("outs", {asc, hold, mode, pdn, crst, oe_n}, 7'h41);
    host.xfer(1'b1, 15'h0005, 1);
    chk("unmapped", host.rx[0], 8'h00);
    t_stream();
    for (int m = 0; m < 4; m++) begin
      wr(`SCRB_OFS_PWR, 8'(m));
      chk("mode", {pdn, mode}, {m == 3, 2'(m)});
    end
    $display("mode test done");
    t_srst();
    report_and_stop();
  end
endmodule // scrb_spi_config_register_bank_test
bind scrb_spi_config_register_bank scrb_cfg_checker chk_i (.clk_sys(clk_sys),
  .reset_n(reset_n), .spi_csn_pin(spi_csn_pin), .spi_sdo_oe_n_q(spi_sdo_oe_n_q),
  .ascend_q(ascend_q), .addr_hold_q(addr_hold_q), .op_mode_q(op_mode_q),
  .power_down_q(power_down_q), .chip_reset_q(chip_reset_q));
`default_nettype wire
